// *** hdl/cis_pkg.sv ***
package cis_pkg;

  typedef enum logic [4:0] {
    CIS_OP_NO_OPERATION   = 5'h00,
    CIS_OP_BITWISE_INVERT = 5'h01,
    CIS_OP_OR_IMMEDIATE   = 5'h02,
    CIS_OP_MINUS_REGISTER = 5'h03,
    CIS_OP_MINUS_TO_ADDR  = 5'h04,
    CIS_OP_MINUS_IMM      = 5'h05,
    CIS_OP_MINUS_QUICK    = 5'h06,
    CIS_OP_MINUS_EXTEND   = 5'h07,
    CIS_OP_SATURATE       = 5'h08,
    CIS_OP_REM_SIGNED     = 5'h09,
    CIS_OP_REM_UNSIGNED   = 5'h0A,
    CIS_OP_SET_ON_COND    = 5'h0B,
    CIS_OP_TEST_AND_SET   = 5'h0C,
    CIS_OP_FREEZE_CORE    = 5'h0D,
    CIS_OP_CACHE_FLUSH    = 5'h0E,
    CIS_OP_PREFETCH_TOUCH = 5'h0F,
    CIS_OP_CTRL_REG_WRITE = 5'h10,
    CIS_OP_SLEEP_LOAD     = 5'h11,
    CIS_OP_DEBUG_PULSE    = 5'h12
  } cis_op_t;

  typedef enum logic [1:0] {
    CIS_FLUSH_ICACHE = 2'h0,
    CIS_FLUSH_DCACHE = 2'h1,
    CIS_FLUSH_BOTH   = 2'h2
  } cis_flush_t;

  // Control register selector codes
  localparam logic [11:0] CIS_SEL_CACHE_CFG = 12'h002;
  localparam logic [11:0] CIS_SEL_ACR_FIRST = 12'h004;
  localparam logic [11:0] CIS_SEL_ACR_LAST  = 12'h007;
  localparam logic [11:0] CIS_SEL_VEC_BASE  = 12'h801;
  localparam logic [11:0] CIS_SEL_RAM_BASE0 = 12'hC04;
  localparam logic [11:0] CIS_SEL_RAM_BASE1 = 12'hC05;

  localparam logic [31:0] CIS_PC_STEP      = 32'h0000_0002;
  localparam logic [31:0] CIS_SAT_NEG      = 32'h8000_0000;
  localparam logic [31:0] CIS_SAT_POS      = 32'h7FFF_FFFF;
  localparam int          CIS_TAS_BIT      = 7;
  localparam logic [3:0]  CIS_PST_PULSE    = 4'h4;

  // Register map, byte addresses
  localparam logic [7:0] CIS_REG_CTRL      = 8'h00;
  localparam logic [7:0] CIS_REG_STATUS    = 8'h04;
  localparam logic [7:0] CIS_REG_PC        = 8'h08;
  localparam logic [7:0] CIS_REG_CACHE_CFG = 8'h0C;
  localparam logic [7:0] CIS_REG_ACCESS_CTRL_0_REG      = 8'h10;
  localparam logic [7:0] CIS_REG_VEC_BASE  = 8'h20;
  localparam logic [7:0] CIS_REG_RAM_BASE0 = 8'h24;
  localparam logic [7:0] CIS_REG_RAM_BASE1 = 8'h28;

  // Control register fields
  localparam int CIS_CTRL_USER_HALT = 0;
  localparam int CIS_CTRL_RESUME    = 1;
  // Status register fields
  localparam int CIS_STAT_HALTED    = 0;
  localparam int CIS_STAT_STOPPED   = 1;
  localparam int CIS_STAT_SR_LSB    = 16;

  localparam logic [31:0] CIS_PC_RESET  = 32'h0000_0000;
  localparam logic [15:0] CIS_SR_RESET  = 16'h2700;
  localparam logic [31:0] CIS_REG_RESET = 32'h0000_0000;

endpackage

// *** hdl/cis_exec.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - no_operation waits for pipeline sync, then PC advances by 2, nothing else.
// - bitwise_invert writes the ones complement of the data register.
// - or_immediate ORs a 32-bit immediate into the data register.
// - minus_register and minus_to_address_reg write destination minus source.
// - minus_immediate and minus_quick write destination minus immediate.
// - minus_with_extend writes destination minus source minus extend flag.
// - saturate_on_overflow loads 0x80000000 or 0x7FFFFFFF when overflow set.
// - remainder instructions write the 32-bit signed or unsigned remainder.
// - set_on_condition writes low byte all ones if condition true, else zeros.
// - test_and_set sets flags from byte, then sets bit 7 in memory.
// - freeze_core halts; supervisor only unless user_halt_allow set.
// - cache_line_flush invalidates I line, pushes D line, or both.
// - instruction_prefetch_touch accesses instruction space at the address register.
// - control_register_write selector 0x002 writes cache_config_reg.
// - selectors 0x004 to 0x007 write access control registers 0 to 3.
// - selector 0x801 writes vector_table_base.
// - selectors 0xC04 and 0xC05 write on-chip RAM base registers 0 and 1.
// - sleep_with_status_load loads 16-bit status_word, then stops the core.
module cis_exec #(
  parameter int DATA_W = 32
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Instruction issue
  input  wire logic                 op_valid_i,
  input  wire cis_pkg::cis_op_t     op_code_i,
  input  wire logic [DATA_W-1:0]    op_dst_i,
  input  wire logic [DATA_W-1:0]    op_src_i,
  input  wire logic [DATA_W-1:0]    op_imm_i,
  input  wire logic [11:0]          op_sel_i,
  input  wire cis_pkg::cis_flush_t  op_flush_i,
  input  wire logic                 op_cond_i,
  input  wire logic                 op_x_i,
  input  wire logic                 op_v_i,
  input  wire logic                 op_super_i,
  input  wire logic                 pipe_sync_i,
  output logic                      op_ready_o,
  // Results
  output logic                      done_o,
  output logic [DATA_W-1:0]         res_data_o,
  output logic                      res_we_o,
  output logic [4:0]                flags_o,
  output logic                      flags_we_o,
  output logic [DATA_W-1:0]         pc_o,
  output logic                      priv_viol_o,
  output logic                      div_zero_o,
  output logic                      mem_we_o,
  output logic [7:0]                mem_byte_o,
  output logic                      cache_req_o,
  output cis_pkg::cis_flush_t       cache_op_o,
  output logic [DATA_W-1:0]         cache_addr_o,
  output logic                      touch_req_o,
  output logic [DATA_W-1:0]         touch_addr_o,
  output logic [3:0]                pst_o,
  output logic                      halted_o,
  output logic                      stopped_o,
  output logic [15:0]               status_word_o,
  // Classic Wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [7:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic [31:0]               dat_o,
  output logic                      ack_o
);
  import cis_pkg::*;

  // Whole block state; pulse fields are cleared each cycle below
  typedef struct packed {
    logic [DATA_W-1:0]      pc;
    logic [DATA_W-1:0]      res;
    logic                   res_we;
    logic [4:0]             flg;
    logic                   flg_we;
    logic                   done;
    logic                   priv;
    logic                   dzero;
    logic                   mem_we;
    logic [7:0]             mem_byte;
    logic                   cache_req;
    cis_flush_t             cache_op;
    logic [DATA_W-1:0]      cache_addr;
    logic                   touch;
    logic [DATA_W-1:0]      touch_addr;
    logic [3:0]             pst;
    logic                   halted;
    logic                   stopped;
    logic [15:0]            sr;
    logic                   uha;
    logic [31:0]            cache_cfg;
    logic [3:0][31:0]       acr;
    logic [31:0]            vector_table_base;
    logic [31:0]            ram0;
    logic [31:0]            ram1;
    logic                   ack;
    logic [31:0]            rdat;
  } cis_state_t;

  cis_state_t st;
  cis_state_t next_st;

  // Flags order: {X, N, Z, V, C}
  function automatic logic [4:0] sub_flags(input logic [DATA_W-1:0] d,
                                           input logic [DATA_W-1:0] s,
                                           input logic              x);
    logic [DATA_W:0]   diff;
    logic              v;
    diff = {1'b0, d} - {1'b0, s} - {{DATA_W{1'b0}}, x};
    v = (d[DATA_W-1] ^ s[DATA_W-1]) & (d[DATA_W-1] ^ diff[DATA_W-1]);
    sub_flags = {diff[DATA_W], diff[DATA_W-1], diff[DATA_W-1:0] == '0, v, diff[DATA_W]};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = wdat[8*i +: 8];
      end
    end
    merge = m;
  endfunction

  logic              bus_req;
  logic              take;
  logic              user_blocked;
  logic [DATA_W-1:0] rem_s;
  logic [DATA_W-1:0] rem_u;
  logic              src_zero;

  assign bus_req = cyc_i & stb_i & ~st.ack;
  // Core accepts work only while running; no_operation holds until pipes agree
  assign op_ready_o = ~st.halted & ~st.stopped &
                      ~((op_code_i == CIS_OP_NO_OPERATION) & ~pipe_sync_i);
  assign take = op_valid_i & op_ready_o;
  // A zero divisor leaves the destination alone and pulses div_zero_o
  assign src_zero = (op_src_i == '0);
  assign rem_s = src_zero ? '0 : DATA_W'($signed(op_dst_i) % $signed(op_src_i));
  assign rem_u = src_zero ? '0 : op_dst_i % op_src_i;

  // Supervisor-only codes; freeze_core may be opened to user mode
  always_comb begin
    user_blocked = 1'b0;
    if (!op_super_i) begin
      case (op_code_i)
        CIS_OP_FREEZE_CORE:    user_blocked = ~st.uha;
        CIS_OP_CACHE_FLUSH,
        CIS_OP_PREFETCH_TOUCH,
        CIS_OP_CTRL_REG_WRITE,
        CIS_OP_SLEEP_LOAD:     user_blocked = 1'b1;
        default:               user_blocked = 1'b0;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    next_st.done      = 1'b0;
    next_st.res_we    = 1'b0;
    next_st.flg_we    = 1'b0;
    next_st.priv      = 1'b0;
    next_st.dzero     = 1'b0;
    next_st.mem_we    = 1'b0;
    next_st.cache_req = 1'b0;
    next_st.touch     = 1'b0;
    next_st.pst       = 4'h0;
    next_st.ack       = 1'b0;

    if (take) begin
      // Refused ops still retire: done pulses and the PC steps
      next_st.done = 1'b1;
      next_st.pc   = st.pc + CIS_PC_STEP;
      if (user_blocked) begin
        next_st.priv = 1'b1;
      end else begin
        case (op_code_i)
          CIS_OP_NO_OPERATION: begin
            next_st.done = 1'b1;
          end
          CIS_OP_BITWISE_INVERT: begin
            next_st.res    = ~op_dst_i;
            next_st.res_we = 1'b1;
            next_st.flg    = {st.flg[4], ~op_dst_i[DATA_W-1], op_dst_i == '1, 2'b00};
            next_st.flg_we = 1'b1;
          end
          CIS_OP_OR_IMMEDIATE: begin
            next_st.res    = op_dst_i | op_imm_i;
            next_st.res_we = 1'b1;
            next_st.flg    = {st.flg[4], next_st.res[DATA_W-1], next_st.res == '0, 2'b00};
            next_st.flg_we = 1'b1;
          end
          CIS_OP_MINUS_REGISTER: begin
            next_st.res    = op_dst_i - op_src_i;
            next_st.res_we = 1'b1;
            next_st.flg    = sub_flags(op_dst_i, op_src_i, 1'b0);
            next_st.flg_we = 1'b1;
          end
          CIS_OP_MINUS_TO_ADDR: begin
            next_st.res    = op_dst_i - op_src_i;
            next_st.res_we = 1'b1;
          end
          CIS_OP_MINUS_IMM,
          CIS_OP_MINUS_QUICK: begin
            next_st.res    = op_dst_i - op_imm_i;
            next_st.res_we = 1'b1;
            next_st.flg    = sub_flags(op_dst_i, op_imm_i, 1'b0);
            next_st.flg_we = 1'b1;
          end
          CIS_OP_MINUS_EXTEND: begin
            next_st.res    = op_dst_i - op_src_i - {{(DATA_W-1){1'b0}}, op_x_i};
            next_st.res_we = 1'b1;
            next_st.flg    = sub_flags(op_dst_i, op_src_i, op_x_i);
            next_st.flg_we = 1'b1;
          end
          CIS_OP_SATURATE: begin
            if (op_v_i) begin
              next_st.res    = op_dst_i[DATA_W-1] ? CIS_SAT_POS : CIS_SAT_NEG;
              next_st.res_we = 1'b1;
            end
          end
          CIS_OP_REM_SIGNED,
          CIS_OP_REM_UNSIGNED: begin
            if (src_zero) begin
              next_st.dzero = 1'b1;
            end else begin
              next_st.res    = (op_code_i == CIS_OP_REM_SIGNED) ? rem_s : rem_u;
              next_st.res_we = 1'b1;
            end
          end
          CIS_OP_SET_ON_COND: begin
            next_st.res    = {op_dst_i[DATA_W-1:8], {8{op_cond_i}}};
            next_st.res_we = 1'b1;
          end
          CIS_OP_TEST_AND_SET: begin
            next_st.flg      = {st.flg[4], op_dst_i[CIS_TAS_BIT], op_dst_i[7:0] == 8'h00,
                                2'b00};
            next_st.flg_we   = 1'b1;
            next_st.mem_byte = op_dst_i[7:0];
            next_st.mem_byte[CIS_TAS_BIT] = 1'b1;
            next_st.mem_we   = 1'b1;
          end
          CIS_OP_FREEZE_CORE: begin
            next_st.halted = 1'b1;
          end
          CIS_OP_CACHE_FLUSH: begin
            next_st.cache_req  = 1'b1;
            next_st.cache_op   = op_flush_i;
            next_st.cache_addr = op_src_i;
          end
          CIS_OP_PREFETCH_TOUCH: begin
            next_st.touch      = 1'b1;
            next_st.touch_addr = op_src_i;
          end
          // Unlisted selectors fall through and touch no control register
          CIS_OP_CTRL_REG_WRITE: begin
            if (op_sel_i == CIS_SEL_CACHE_CFG) begin
              next_st.cache_cfg = op_src_i;
            end else if (op_sel_i >= CIS_SEL_ACR_FIRST && op_sel_i <= CIS_SEL_ACR_LAST) begin
              next_st.acr[op_sel_i[1:0]] = op_src_i;
            end else if (op_sel_i == CIS_SEL_VEC_BASE) begin
              next_st.vector_table_base = op_src_i;
            end else if (op_sel_i == CIS_SEL_RAM_BASE0) begin
              next_st.ram0 = op_src_i;
            end else if (op_sel_i == CIS_SEL_RAM_BASE1) begin
              next_st.ram1 = op_src_i;
            end else begin
              next_st.cache_cfg = st.cache_cfg;
            end
          end
          CIS_OP_SLEEP_LOAD: begin
            next_st.sr      = op_imm_i[15:0];
            next_st.stopped = 1'b1;
          end
          CIS_OP_DEBUG_PULSE: begin
            next_st.pst = CIS_PST_PULSE;
          end
          default: begin
            next_st.done = 1'b1;
          end
        endcase
      end
    end

    // Register bus; a resume written in the same cycle as a halt loses
    if (bus_req) begin
      next_st.ack  = 1'b1;
      next_st.rdat = 32'h0000_0000;
      case (adr_i)
        CIS_REG_CTRL: begin
          next_st.rdat[CIS_CTRL_USER_HALT] = st.uha;
          if (we_i && sel_i[0]) begin
            next_st.uha = dat_i[CIS_CTRL_USER_HALT];
            if (dat_i[CIS_CTRL_RESUME] && !take) begin
              next_st.halted  = 1'b0;
              next_st.stopped = 1'b0;
            end
          end
        end
        CIS_REG_STATUS: begin
          next_st.rdat[CIS_STAT_HALTED]  = st.halted;
          next_st.rdat[CIS_STAT_STOPPED] = st.stopped;
          next_st.rdat[CIS_STAT_SR_LSB +: 16] = st.sr;
        end
        CIS_REG_PC: begin
          next_st.rdat = st.pc;
          if (we_i && !take) begin
            next_st.pc = merge(st.pc, dat_i, sel_i);
          end
        end
        CIS_REG_CACHE_CFG:          next_st.rdat = st.cache_cfg;
        CIS_REG_ACCESS_CTRL_0_REG,
        CIS_REG_ACCESS_CTRL_0_REG + 8'h04,
        CIS_REG_ACCESS_CTRL_0_REG + 8'h08,
        CIS_REG_ACCESS_CTRL_0_REG + 8'h0C:       next_st.rdat = st.acr[adr_i[3:2]];
        CIS_REG_VEC_BASE:           next_st.rdat = st.vector_table_base;
        CIS_REG_RAM_BASE0:          next_st.rdat = st.ram0;
        CIS_REG_RAM_BASE1:          next_st.rdat = st.ram1;
        default:                    next_st.rdat = 32'h0000_0000;
      endcase
      // Reads off a word boundary return zero
      if (!we_i && adr_i[1:0] != 2'b00) begin
        next_st.rdat = 32'h0000_0000;
      end
    end
  end

  // Clear first, then load the named reset values of five fields; only sr is not zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st           <= '0;
      st.pc        <= CIS_PC_RESET;
      st.sr        <= CIS_SR_RESET;
      st.cache_cfg <= CIS_REG_RESET;
      st.vector_table_base       <= CIS_REG_RESET;
      st.cache_op  <= CIS_FLUSH_ICACHE;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a state flop; only op_ready_o is combinational
  assign done_o        = st.done;
  assign res_data_o    = st.res;
  assign res_we_o      = st.res_we;
  assign flags_o       = st.flg;
  assign flags_we_o    = st.flg_we;
  assign pc_o          = st.pc;
  assign priv_viol_o   = st.priv;
  assign div_zero_o    = st.dzero;
  assign mem_we_o      = st.mem_we;
  assign mem_byte_o    = st.mem_byte;
  assign cache_req_o   = st.cache_req;
  assign cache_op_o    = st.cache_op;
  assign cache_addr_o  = st.cache_addr;
  assign touch_req_o   = st.touch;
  assign touch_addr_o  = st.touch_addr;
  assign pst_o         = st.pst;
  assign halted_o      = st.halted;
  assign stopped_o     = st.stopped;
  assign status_word_o = st.sr;
  assign dat_o         = st.rdat;
  assign ack_o         = st.ack;

endmodule

// *** testbench/cis_exec_asserts.sv ***
`timescale 1ns/10ps
module cis_exec_asserts #(
  parameter int DATA_W = 32
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                op_valid_i,
  input wire cis_pkg::cis_op_t    op_code_i,
  input wire logic [DATA_W-1:0]   op_dst_i,
  input wire logic                op_v_i,
  input wire logic                op_super_i,
  input wire logic                pipe_sync_i,
  input wire logic                op_ready_o,
  input wire logic                done_o,
  input wire logic                res_we_o,
  input wire logic [DATA_W-1:0]   res_data_o,
  input wire logic [DATA_W-1:0]   pc_o,
  input wire logic                priv_viol_o,
  input wire logic                cache_req_o,
  input wire logic                touch_req_o,
  input wire logic                mem_we_o,
  input wire logic [7:0]          mem_byte_o,
  input wire logic                halted_o
);
  import cis_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  assign take = op_valid_i && op_ready_o;
  sequence s_held;
    halted_o && !op_ready_o;
  endsequence
  a_op_done: assert property (take |=> done_o)
    else $error("no done after accepted op");
  a_pc_step: assert property (take |=> pc_o == $past(pc_o) + 32'h2)
    else $error("pc did not advance by two");
  a_nop_sync: assert property (
    op_code_i == CIS_OP_NO_OPERATION && !pipe_sync_i |-> !op_ready_o)
    else $error("no-op taken without sync");
  a_halt_stall: assert property (
    take && op_code_i == CIS_OP_FREEZE_CORE && op_super_i |=> s_held)
    else $error("freeze did not halt");
  a_user_priv: assert property (
    take && !op_super_i && op_code_i inside {CIS_OP_CACHE_FLUSH,
    CIS_OP_PREFETCH_TOUCH, CIS_OP_CTRL_REG_WRITE, CIS_OP_SLEEP_LOAD}
    |=> priv_viol_o && !cache_req_o && !touch_req_o)
    else $error("user op not refused");
  a_priv_quiet: assert property (priv_viol_o |-> !res_we_o && !mem_we_o)
    else $error("refused op wrote state");
  a_sat_value: assert property (
    take && op_code_i == CIS_OP_SATURATE && op_v_i |=> res_we_o &&
    res_data_o == ($past(op_dst_i) >= 32'h8000_0000 ? 32'h7FFF_FFFF : 32'h8000_0000))
    else $error("saturate value wrong");
  a_sat_keep: assert property (
    take && op_code_i == CIS_OP_SATURATE && !op_v_i |=> !res_we_o)
    else $error("saturate wrote without overflow");
  a_tas_byte: assert property (
    take && op_code_i == CIS_OP_TEST_AND_SET |=> mem_we_o &&
    {24'h000000, mem_byte_o} == (($past(op_dst_i) & 32'h0000_00FF) | 32'h0000_0080))
    else $error("test and set byte wrong");
endmodule

bind cis_exec cis_exec_asserts #(.DATA_W(DATA_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
  .op_dst_i(op_dst_i), .op_v_i(op_v_i), .op_super_i(op_super_i), .pipe_sync_i(pipe_sync_i),
  .op_ready_o(op_ready_o), .done_o(done_o), .res_we_o(res_we_o), .res_data_o(res_data_o),
  .pc_o(pc_o), .priv_viol_o(priv_viol_o), .cache_req_o(cache_req_o),
  .touch_req_o(touch_req_o), .mem_we_o(mem_we_o), .mem_byte_o(mem_byte_o), .halted_o(halted_o)
);

// *** testbench/cis_exec_test.sv ***
`timescale 1ns/10ps
module cis_exec_test;
  import cis_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, op_valid_i = 1'b0, op_cond_i = 1'b0, op_x_i = 1'b0;
  logic        op_v_i = 1'b0, op_super_i = 1'b1, pipe_sync_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [31:0] op_dst_i = 32'h0, op_src_i = 32'h0, op_imm_i = 32'h0, dat_i = 32'h0, rd;
  logic [11:0] op_sel_i = 12'h000;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  cis_op_t     op_code_i = CIS_OP_NO_OPERATION;
  cis_flush_t  op_flush_i = CIS_FLUSH_ICACHE;
  logic        op_ready_o, done_o, res_we_o, flags_we_o, priv_viol_o, div_zero_o, mem_we_o;
  logic        cache_req_o, touch_req_o, halted_o, stopped_o, ack_o;
  logic [31:0] res_data_o, pc_o, cache_addr_o, touch_addr_o, dat_o;
  logic [15:0] status_word_o;
  logic [7:0]  mem_byte_o;
  logic [4:0]  flags_o;
  logic [3:0]  pst_o;
  cis_flush_t  cache_op_o;
  int          miscompares = 0;
  int          n_tests = 0;
  logic [11:0] sels [8] = '{12'h002, 12'h004, 12'h005, 12'h006, 12'h007, 12'h801, 12'hC04,
                            12'hC05};
  logic [7:0]  adrs [8] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
  cis_op_t     uops [5] = '{CIS_OP_CACHE_FLUSH, CIS_OP_PREFETCH_TOUCH, CIS_OP_CTRL_REG_WRITE,
                            CIS_OP_SLEEP_LOAD, CIS_OP_FREEZE_CORE};

  cis_exec dut (
    .clk_i, .rst_i, .op_valid_i, .op_code_i, .op_dst_i, .op_src_i, .op_imm_i, .op_sel_i,
    .op_flush_i, .op_cond_i, .op_x_i, .op_v_i, .op_super_i, .pipe_sync_i, .op_ready_o, .done_o,
    .res_data_o, .res_we_o, .flags_o, .flags_we_o, .pc_o, .priv_viol_o, .div_zero_o, .mem_we_o,
    .mem_byte_o, .cache_req_o, .cache_op_o, .cache_addr_o, .touch_req_o, .touch_addr_o,
    .pst_o, .halted_o, .stopped_o, .status_word_o, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o
  );

  always #4 clk_i = ~clk_i;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    #1;
  endtask

  // Aux packs {overflow, extend, condition, flush kind, selector}
  task automatic issue(input cis_op_t c, input logic [31:0] d, s, m, input logic sup,
                       input logic [16:0] aux);
    int n;
    n = 0;
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_dst_i <= d;
    op_src_i <= s;
    op_imm_i <= m;
    op_super_i <= sup;
    {op_v_i, op_x_i, op_cond_i, op_sel_i} <= {aux[16:14], aux[11:0]};
    op_flush_i <= cis_flush_t'(aux[13:12]);
    @(posedge clk_i);
    while (op_ready_o !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    if (n == 20) miscompares++;
    op_valid_i <= 1'b0;
    #1;
  endtask

  task automatic arith(input cis_op_t c, input logic [31:0] d, s, m, input logic [16:0] aux,
                       input logic [31:0] exp);
    issue(c, d, s, m, 1'b1, aux);
    check("res", {res_we_o, done_o, res_data_o[29:0]}, {2'b11, exp[29:0]});
    check("res_hi", res_data_o, exp);
  endtask

  task automatic t_reset;
    #1;
    check("pc_rst", pc_o, 32'h0);
    check("sw_rst", status_word_o, 32'h2700);
    wb(1'b0, CIS_REG_STATUS, 32'h0);
    check("stat_rst", rd, 32'h2700_0000);
    wb(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
  endtask

  task automatic t_arith;
    arith(CIS_OP_BITWISE_INVERT, 32'h0F0F00FF, 32'h0, 32'h0, 17'h0, 32'hF0F0FF00);
    arith(CIS_OP_OR_IMMEDIATE, 32'h12340000, 32'h0, 32'hABCD, 17'h0, 32'h1234ABCD);
    arith(CIS_OP_MINUS_REGISTER, 32'h5, 32'h3, 32'h0, 17'h0, 32'h2);
    arith(CIS_OP_MINUS_TO_ADDR, 32'h1000, 32'h1001, 32'h0, 17'h0, 32'hFFFFFFFF);
    arith(CIS_OP_MINUS_IMM, 32'h64, 32'h0, 32'h1, 17'h0, 32'h63);
    arith(CIS_OP_MINUS_QUICK, 32'h0, 32'h0, 32'h8, 17'h0, 32'hFFFFFFF8);
    arith(CIS_OP_MINUS_EXTEND, 32'hA, 32'h3, 32'h0, 17'h08000, 32'h6);
    arith(CIS_OP_SATURATE, 32'h5, 32'h0, 32'h0, 17'h10000, 32'h80000000);
    arith(CIS_OP_SATURATE, 32'h80000000, 32'h0, 32'h0, 17'h10000, 32'h7FFFFFFF);
    arith(CIS_OP_REM_SIGNED, 32'hFFFFFFF9, 32'h2, 32'h0, 17'h0, 32'hFFFFFFFF);
    arith(CIS_OP_REM_UNSIGNED, 32'hFFFFFFF9, 32'h2, 32'h0, 17'h0, 32'h1);
    arith(CIS_OP_SET_ON_COND, 32'h12345600, 32'h0, 32'h0, 17'h04000, 32'h123456FF);
    arith(CIS_OP_SET_ON_COND, 32'h123456AB, 32'h0, 32'h0, 17'h0, 32'h12345600);
    issue(CIS_OP_SATURATE, 32'h5, 32'h0, 32'h0, 1'b1, 17'h0);
    check("sat_keep", res_we_o, 32'h0);
    issue(CIS_OP_REM_UNSIGNED, 32'h9, 32'h0, 32'h0, 1'b1, 17'h0);
    check("div_zero", {res_we_o, div_zero_o}, 32'h1);
    issue(CIS_OP_TEST_AND_SET, 32'h41, 32'h0, 32'h0, 1'b0, 17'h0);
    check("tas", {flags_we_o, mem_we_o, mem_byte_o}, 32'h3C1);
    check("tas_flags", flags_o, 32'h00);
    issue(CIS_OP_TEST_AND_SET, 32'h00, 32'h0, 32'h0, 1'b1, 17'h0);
    check("tas_zero", {flags_o, mem_byte_o}, 32'h480);
  endtask

  task automatic t_cache;
    for (int f = 0; f < 3; f++) begin
      issue(CIS_OP_CACHE_FLUSH, 32'h0, 32'h40 + f, 32'h0, 1'b1, {3'b000, f[1:0], 12'h000});
      check("flush", {cache_req_o, cache_op_o}, {29'h0, 1'b1, f[1:0]});
      check("flush_adr", cache_addr_o, 32'h40 + f);
    end
    issue(CIS_OP_PREFETCH_TOUCH, 32'h0, 32'h2000, 32'h0, 1'b1, 17'h0);
    check("touch", {touch_req_o, touch_addr_o[30:0]}, 32'h80002000);
  endtask

  task automatic t_ctrl;
    for (int i = 0; i < 8; i++) begin
      issue(CIS_OP_CTRL_REG_WRITE, 32'h0, 32'hA0 + i, 32'h0, 1'b1, {5'h0, sels[i]});
    end
    issue(CIS_OP_CTRL_REG_WRITE, 32'h0, 32'hDEAD, 32'h0, 1'b1, 17'h003);
    issue(CIS_OP_CTRL_REG_WRITE, 32'h0, 32'hDEAD, 32'h0, 1'b1, 17'h800);
    foreach (uops[i]) begin
      issue(uops[i], 32'h0, 32'h40, 32'h55, 1'b0, 17'h002);
      check("user", {priv_viol_o, cache_req_o | touch_req_o | stopped_o | halted_o},
            32'h2);
    end
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, adrs[i], 32'h0);
      check("ctrl_reg", rd, 32'hA0 + i);
    end
  endtask

  task automatic t_halt;
    wb(1'b1, CIS_REG_CTRL, 32'h1);
    issue(CIS_OP_FREEZE_CORE, 32'h0, 32'h0, 32'h0, 1'b0, 17'h0);
    check("uhalt", {priv_viol_o, halted_o, op_ready_o}, 32'h2);
    wb(1'b0, CIS_REG_STATUS, 32'h0);
    check("stat_halt", rd, 32'h2700_0001);
    wb(1'b1, CIS_REG_CTRL, 32'h2);
    check("resume", halted_o, 32'h0);
    issue(CIS_OP_FREEZE_CORE, 32'h0, 32'h0, 32'h0, 1'b1, 17'h0);
    check("shalt", {priv_viol_o, halted_o, op_ready_o}, 32'h2);
    wb(1'b1, CIS_REG_CTRL, 32'h2);
    issue(CIS_OP_SLEEP_LOAD, 32'h0, 32'h0, 32'h2512, 1'b1, 17'h0);
    check("sleep", {stopped_o, op_ready_o, status_word_o}, {16'h2, 16'h2512});
    wb(1'b1, CIS_REG_CTRL, 32'h2);
  endtask

  task automatic t_nop;
    rd = pc_o;
    @(posedge clk_i);
    pipe_sync_i <= 1'b0;
    op_code_i <= CIS_OP_NO_OPERATION;
    op_valid_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    check("nop_wait", {op_ready_o, done_o, pc_o[29:0]}, {2'b00, rd[29:0]});
    @(posedge clk_i);
    pipe_sync_i <= 1'b1;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1;
    check("nop_pc", pc_o, rd + 32'h2);
    check("nop_quiet", {res_we_o, mem_we_o, cache_req_o, halted_o, pst_o}, 32'h0);
  endtask

  task automatic t_pulse;
    issue(CIS_OP_DEBUG_PULSE, 32'h0, 32'h0, 32'h0, 1'b0, 17'h0);
    check("pulse", {done_o, pst_o}, 32'h14);
    @(posedge clk_i);
    #1;
    check("pulse_end", pst_o, 32'h0);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_arith;
    t_cache;
    t_ctrl;
    t_halt;
    t_nop;
    t_pulse;
    print_verdict;
  end

  // Watchdog sized well above the roughly 140 cycles the sequence needs
  initial begin
    #(8 * 3000);
    miscompares++;
    print_verdict;
  end
endmodule
